//--- inc/spi_port_defines.vh
/*
 constants for the three-wire serial port: divider, burst pacing, field widths.
 assumes a single 200 MHz clock; included by bare name from the design file.
*/
// Function
// - master drives serial clock, samples miso side, drives mosi side.
// - slave takes serial clock in, drives miso side, samples mosi side.
// - compat mode: miso side always output, mosi side always input, select ignored.
// - every serial clock cycle shifts one bit out and one bit in.
// - slave with select enabled: select high floats the serial output driver.
// - master bit rate is input clock over four times two to the code.
// - faster variant rates scale with system clock, same divisor law.
// - codes five and faster send byte pairs with fixed pair spacing.
// - slave never paces, so overruns occur; master paces every byte.
// - clock idles high by default, invert makes it idle low.
// - edge option selects phase: negative gives cpha 0, positive cpha 1.
// - idle high with negative edge samples on fall; idle low on rise.
// - cpha 1 presents on first transition, latches on second.
// - cpha 0 presents before first transition, latches on it.
// - clock code defaults to zero and only matters in master role.
// - edge option defaults to positive, phase one.
// - one transfer moves at most 255 bytes each way, then signals done.
`ifndef SPI_PORT_DEFINES_VH
`define SPI_PORT_DEFINES_VH
`define CLK_MHZ 200
`define HALF_BASE 9'h002
`define CODE_DEFAULT 3'h0
`define BURST_MAX_CODE 3'h5
`define PAIR_SPACING_US 400
`define PAIR_SPACING_REF_MHZ 10
`define PAIR_SPACING_CYC (`PAIR_SPACING_US * `PAIR_SPACING_REF_MHZ)
`define BYTE_LAST_BIT 3'h7
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

//--- verilog/spi_port_master_slave.v
/*
 three-wire full-duplex serial port, master or slave, with a receive fifo.
 assumes pin inputs are already synchronous to clk_in; the pad ring resolves
 each pin from its _out and _oe pair.
*/
`include "spi_port_defines.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// receive fifo, registered output stage in front of the storage
module rx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // fill side
   input wire [WIDTH-1:0] in_data_in,
   input wire in_valid_in,
   output reg in_ready_out,
   // drain side
   output reg [WIDTH-1:0] out_data_out,
   output reg out_valid_out,
   input wire out_ready_in
);
   localparam [AW:0] DEPTH_C = DEPTH;
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push = in_valid_in && in_ready_out;
   wire pop = (count_r != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);
   wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // storage needs no reset, pointers guard it
   always @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   // pointers, level and output stage
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
         out_data_out <= {WIDTH{1'b0}};
      end else begin
         count_r <= count_nxt;
         in_ready_out <= (count_nxt != DEPTH_C);  // registered, so full shows one cycle late-free
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            out_data_out <= mem_r[rd_ptr_r];
            out_valid_out <= 1'b1;
         end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// serial engine
module spi_port_master_slave (
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // configuration, role bits caught once after reset
   input wire master_mode_in,
   input wire compat_mode_in,
   input wire select_enable_in,
   input wire [2:0] clock_code_in,
   input wire clock_edge_pos_in,
   input wire clock_invert_in,
   // transfer control and status
   input wire start_in,
   input wire [7:0] byte_count_in,
   output reg busy_out,
   output reg done_out,
   output reg overrun_out,
   input wire clear_overrun_in,
   // transmit bytes
   input wire [7:0] tx_data_in,
   output reg tx_taken_out,
   // receive bytes
   output wire [7:0] rx_data_out,
   output wire rx_valid_out,
   input wire rx_ready_in,
   // serial pins
   input wire serial_clock_pin_in,
   output reg serial_clock_pin_out,
   output reg serial_clock_pin_oe_out,
   input wire data_pin_miso_side_in,
   output reg data_pin_miso_side_out,
   output reg data_pin_miso_side_oe_out,
   input wire data_pin_mosi_side_in,
   output reg data_pin_mosi_side_out,
   output reg data_pin_mosi_side_oe_out,
   input wire slave_select_pin_in
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_LOAD = 2'h1;
   localparam [1:0] ST_SHIFT = 2'h2;
   localparam [11:0] SPACING_C = `PAIR_SPACING_CYC;

   // half serial period minus one, in clk_in cycles
   function [8:0] half_last;
      input [2:0] code;
      begin
         half_last = (`HALF_BASE << code) - 9'h001;
      end
   endfunction

   reg cfg_done_r;
   reg master_r;
   reg compat_r;
   reg sel_en_r;
   reg [2:0] code_r;
   reg cpha_r;
   reg cpol_r;
   reg [1:0] state_r;
   reg [7:0] remain_r;
   reg [2:0] bitcnt_r;
   reg [7:0] tx_sh_r;
   reg [7:0] rx_sh_r;
   reg out_bit_r;
   reg sclk_prev_r;
   reg [8:0] div_r;
   reg pair_second_r;
   reg [11:0] spacing_r;
   reg rx_push_r;
   reg [7:0] rx_byte_r;
   wire fifo_ready;

   ////////////////////////////////////////////////////////////////////////////
   // edge detection, shared by both roles
   wire selected = compat_r || !sel_en_r || !slave_select_pin_in;
   wire shifting = (state_r == ST_SHIFT);
   wire tick = master_r && shifting && (div_r == half_last(code_r));
   wire pin_lead = (serial_clock_pin_in != cpol_r) && (sclk_prev_r == cpol_r);
   wire pin_trail = (serial_clock_pin_in == cpol_r) && (sclk_prev_r != cpol_r);
   wire slave_go = !master_r && selected && shifting;
   wire lead = (tick && serial_clock_pin_out == cpol_r) || (slave_go && pin_lead);
   wire trail = (tick && serial_clock_pin_out != cpol_r) || (slave_go && pin_trail);
   // data in comes from miso side only for a normal master
   wire din = (master_r && !compat_r) ? data_pin_miso_side_in : data_pin_mosi_side_in;
   wire shift_ev = cpha_r ? lead : trail;
   wire sample_ev = cpha_r ? trail : lead;
   wire byte_end = trail && (bitcnt_r == `BYTE_LAST_BIT);
   wire [7:0] rx_full = cpha_r ? {rx_sh_r[6:0], din} : rx_sh_r;
   // pair pacing keeps the average rate down at the fast codes
   wire gap_ok = (code_r > `BURST_MAX_CODE) || pair_second_r || (spacing_r >= SPACING_C);
   wire can_load = !master_r || (fifo_ready && !rx_push_r && gap_ok);

   ////////////////////////////////////////////////////////////////////////////
   // control, shifter and pins
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_done_r <= 1'b0;
         master_r <= 1'b0;
         compat_r <= 1'b0;
         sel_en_r <= 1'b0;
         code_r <= `CODE_DEFAULT;
         cpha_r <= 1'b1;
         cpol_r <= 1'b1;
         state_r <= ST_IDLE;
         remain_r <= 8'h00;
         bitcnt_r <= 3'h0;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         out_bit_r <= 1'b0;
         sclk_prev_r <= 1'b1;
         div_r <= 9'h000;
         pair_second_r <= 1'b0;
         spacing_r <= 12'h000;
         rx_push_r <= 1'b0;
         rx_byte_r <= 8'h00;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         overrun_out <= 1'b0;
         tx_taken_out <= 1'b0;
         serial_clock_pin_out <= 1'b1;
         serial_clock_pin_oe_out <= 1'b0;
         data_pin_miso_side_out <= 1'b0;
         data_pin_miso_side_oe_out <= 1'b0;
         data_pin_mosi_side_out <= 1'b0;
         data_pin_mosi_side_oe_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         tx_taken_out <= 1'b0;
         rx_push_r <= 1'b0;
         sclk_prev_r <= serial_clock_pin_in;
         // role bits are caught once, never changed afterwards
         if (!cfg_done_r) begin
            cfg_done_r <= 1'b1;
            master_r <= master_mode_in;
            compat_r <= compat_mode_in;
            sel_en_r <= select_enable_in;
         end
         if (spacing_r != 12'hfff) begin
            spacing_r <= spacing_r + 12'h001;
         end
         // set wins over clear on the same edge
         if (rx_push_r && !fifo_ready) begin
            overrun_out <= 1'b1;
         end else if (clear_overrun_in) begin
            overrun_out <= 1'b0;
         end
         // pin directions; compat ignores select entirely
         serial_clock_pin_oe_out <= cfg_done_r && master_r;
         data_pin_mosi_side_oe_out <= cfg_done_r && master_r && !compat_r;
         data_pin_miso_side_oe_out <= cfg_done_r && (compat_r || (!master_r && selected));
         data_pin_miso_side_out <= out_bit_r;
         data_pin_mosi_side_out <= out_bit_r;
         case (state_r)
            ST_IDLE: begin
               // clock shape may only change between transfers
               code_r <= clock_code_in;
               cpha_r <= clock_edge_pos_in;
               cpol_r <= !clock_invert_in;
               serial_clock_pin_out <= !clock_invert_in;
               if (start_in && cfg_done_r) begin
                  remain_r <= byte_count_in;
                  busy_out <= 1'b1;
                  pair_second_r <= 1'b0;
                  spacing_r <= SPACING_C;
                  state_r <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               serial_clock_pin_out <= cpol_r;
               if (remain_r == 8'h00) begin
                  done_out <= 1'b1;
                  busy_out <= 1'b0;
                  state_r <= ST_IDLE;
               end else if (can_load) begin
                  tx_taken_out <= 1'b1;
                  bitcnt_r <= 3'h0;
                  div_r <= 9'h000;
                  if (!pair_second_r) begin
                     spacing_r <= 12'h000;
                  end
                  // phase 0 puts the first bit out before any edge
                  if (cpha_r) begin
                     tx_sh_r <= tx_data_in;
                  end else begin
                     out_bit_r <= tx_data_in[7];
                     tx_sh_r <= {tx_data_in[6:0], 1'b0};
                  end
                  state_r <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               div_r <= tick ? 9'h000 : div_r + 9'h001;
               if (tick) begin
                  serial_clock_pin_out <= !serial_clock_pin_out;
               end
               if (shift_ev) begin
                  out_bit_r <= tx_sh_r[7];
                  tx_sh_r <= {tx_sh_r[6:0], 1'b0};
               end
               if (sample_ev) begin
                  rx_sh_r <= {rx_sh_r[6:0], din};
               end
               if (trail) begin
                  bitcnt_r <= bitcnt_r + 3'h1;
               end
               // deselect drops a partial byte so the slave realigns
               if (!master_r && !selected) begin
                  bitcnt_r <= 3'h0;
               end
               if (byte_end) begin
                  rx_push_r <= 1'b1;
                  rx_byte_r <= rx_full;
                  remain_r <= remain_r - 8'h01;
                  pair_second_r <= !pair_second_r;
                  state_r <= ST_LOAD;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer; a full buffer stalls the master, costs the slave a byte
   rx_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_rx_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_data_in(rx_byte_r),
      .in_valid_in(rx_push_r),
      .in_ready_out(fifo_ready),
      .out_data_out(rx_data_out),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in)
   );
endmodule
`default_nettype wire

//--- testbench/spi_port_sva.sv
/*
 port checker for the serial engine, bound to its top module.
 assumes role, compat and select inputs hold still after reset.
*/
`default_nettype none
module spi_port_sva (
   // clock, reset and configuration
   input wire logic clk_in, rst_n_in, master_mode_in, compat_mode_in, select_enable_in, clock_invert_in,
   input wire logic [2:0] clock_code_in,
   // control and status
   input wire logic start_in, busy_out, done_out, overrun_out, tx_taken_out,
   input wire logic [7:0] byte_count_in,
   // pins
   input wire logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe_out, slave_select_pin_in,
   input wire logic data_pin_miso_side_oe_out, data_pin_mosi_side_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] up_r;
   logic [9:0] gap_r;
   logic [3:0] lead_r;
   logic sck_r, seen_r;
   // the clock as it stands on the pin: own driver in master role, far clock otherwise
   wire sck = serial_clock_pin_oe_out ? serial_clock_pin_out : serial_clock_pin_in;
   wire tog = sck != sck_r;
   wire ss = slave_select_pin_in;
   wire up = up_r == 2'h3;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////
   // edge counters; lead count restarts per byte so a lost bit shows
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         up_r <= 2'h0;
         gap_r <= 10'h0;
         lead_r <= 4'h0;
         sck_r <= 1'b1;
         seen_r <= 1'b0;
      end else begin
         up_r <= up ? up_r : up_r + 2'h1;
         sck_r <= sck;
         gap_r <= tog ? 10'h1 : gap_r + 10'h1;
         lead_r <= tx_taken_out ? 4'h0 : lead_r + {3'h0, tog && sck == clock_invert_in};
         seen_r <= done_out ? 1'b0 : seen_r | tx_taken_out;
      end
   end
   ////////////////////////////////////////////////////////////
   // properties
   property p_half; master_mode_in && tog && busy_out && sck != clock_invert_in |->
      gap_r == (10'h2 << clock_code_in); endproperty
   a_half: assert property (p_half) else $error("half period wrong");
   property p_bits; (tx_taken_out || done_out) && seen_r |-> lead_r == 4'h8; endproperty
   a_bits: assert property (p_bits) else $error("clock count per byte wrong");
   property p_clk_oe; up |-> serial_clock_pin_oe_out == master_mode_in; endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock pin direction wrong");
   property p_mosi_oe; up |-> data_pin_mosi_side_oe_out == (master_mode_in && !compat_mode_in); endproperty
   a_mosi_oe: assert property (p_mosi_oe) else $error("mosi side direction wrong");
   property p_float; up && select_enable_in && !master_mode_in && !compat_mode_in && ss && $past(ss) &&
      $past(ss, 2) |-> !data_pin_miso_side_oe_out; endproperty
   a_float: assert property (p_float) else $error("deselected slave drives");
   property p_idle; up && master_mode_in && !busy_out && !$past(busy_out) && $stable(clock_invert_in) &&
      $past(clock_invert_in, 2) == clock_invert_in |-> sck == !clock_invert_in; endproperty
   a_idle: assert property (p_idle) else $error("clock idle level wrong");
   property p_busy; up && start_in && !busy_out && !done_out |=> busy_out; endproperty
   a_busy: assert property (p_busy) else $error("start not taken");
   property p_zero; up && start_in && !busy_out && !done_out && byte_count_in == 8'h0 |-> ##2 done_out; endproperty
   a_zero: assert property (p_zero) else $error("empty transfer not done");
   property p_nover; up && master_mode_in |-> !overrun_out; endproperty
   a_nover: assert property (p_nover) else $error("overrun in master role");
   c_done: cover property (done_out && seen_r);
   c_zero: cover property (start_in && byte_count_in == 8'h0);
   c_compat: cover property (compat_mode_in && done_out);
endmodule
bind spi_port_master_slave spi_port_sva spi_port_sva_i (.*);
`default_nettype wire

//--- testbench/spi_far_side.sv
/*
 behavioural far-side slave for the serial port bench.
 assumes a load pulse before each transfer realigns it.
*/
`default_nettype none
module spi_far_side (
   // clock pin, only ever received here
   input wire logic sclk_in,
   input wire logic idle_in,
   input wire logic cpha_in,
   input wire logic load_in,
   // data
   input wire logic mosi_in,
   input wire logic [7:0] tx_in,
   output logic miso_out,
   output var logic [7:0] rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr = 8'h00;
   logic [2:0] n = 3'h0;
   assign miso_out = sr[7];
   ////////////////////////////////////////////////////////////
   // reload between transfers; idle level changes leave junk behind
   always @(posedge load_in) begin
      n = 3'h0;
      sr = tx_in;
   end
   // lead edge leaves idle; phase picks shift or sample
   always @(sclk_in) begin
      if (sclk_in !== idle_in) begin
         if (cpha_in) sr = (n == 3'h0) ? tx_in : sr << 1;
         else rx_out = {rx_out[6:0], mosi_in};
      end else begin
         if (cpha_in) rx_out = {rx_out[6:0], mosi_in};
         else sr = (n == 3'h7) ? tx_in : sr << 1;
         n = n + 3'h1;
      end
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
 self-checking bench: master transfers over all codes and clock shapes,
 a stalled drain, fixed-direction mode, slave select. assumes a far slave.
*/
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, rst_n_in = 0, ms = 1, cm = 0, se = 0, ep = 0, inv = 0, start = 0;
   logic rdy = 1, clr = 0, ss = 1, load = 0, ssck = 1, sdo = 0;
   logic [2:0] code = 3'h0;
   logic [7:0] cnt = 8'h0, txd = 8'h0, ftx = 8'h0, sq = 8'h0;
   wire busy, done, ovr, taken, rxv, sck_o, sck_oe, miso_o, miso_oe, mosi_o, mosi_oe, fmiso;
   wire [7:0] rxd, frx;
   // bench plays master on the clock pin whenever the port does not drive it
   wire sck = sck_oe ? sck_o : ssck;
   int fails = 0, tests_run = 0, got = 0, dur = 0;
   // fixed-direction mode swaps which data pin carries each way
   spi_port_master_slave spi_port_master_slave_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .master_mode_in(ms),
      .compat_mode_in(cm), .select_enable_in(se), .clock_code_in(code), .clock_edge_pos_in(ep),
      .clock_invert_in(inv), .start_in(start), .byte_count_in(cnt), .busy_out(busy), .done_out(done),
      .overrun_out(ovr), .clear_overrun_in(clr), .tx_data_in(txd), .tx_taken_out(taken), .rx_data_out(rxd),
      .rx_valid_out(rxv), .rx_ready_in(rdy), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
      .serial_clock_pin_oe_out(sck_oe), .data_pin_miso_side_in(cm ? ~fmiso : fmiso),
      .data_pin_miso_side_out(miso_o), .data_pin_miso_side_oe_out(miso_oe),
      .data_pin_mosi_side_in(ms ? (cm ? fmiso : ~fmiso) : sdo), .data_pin_mosi_side_out(mosi_o),
      .data_pin_mosi_side_oe_out(mosi_oe), .slave_select_pin_in(ss));
   spi_far_side spi_far_side_i (.sclk_in(sck), .idle_in(~inv), .cpha_in(ep), .load_in(load),
      .mosi_in(cm ? miso_o : mosi_o), .tx_in(ftx), .miso_out(fmiso), .rx_out(frx));
   ////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial forever #2.5 clk_in = ~clk_in;
   // drain side: every received byte is the far side's byte
   always @(posedge clk_in) if (rxv && rdy) begin
      `CHK("rx_data", ftx, rxd)
      got++;
   end
   // reset into a role; role bits are caught only here
   task automatic reboot(input logic m, c);
      rst_n_in = 0;
      ms = m;
      cm = c;
      repeat (3) @(negedge clk_in);
      rst_n_in = 1;
      repeat (3) @(negedge clk_in);
   endtask
   // one transfer; a nonzero stall holds the drain side off that long
   task automatic xfer(input logic [2:0] c, input logic e, i, input logic [7:0] n, input int stall);
      @(negedge clk_in);
      code = c;
      ep = e;
      inv = i;
      ftx = 8'($urandom);
      txd = 8'($urandom);
      got = 0;
      repeat (4) @(negedge clk_in);
      load = 1;
      @(negedge clk_in);
      load = 0;
      start = 1;
      cnt = n;
      rdy = stall == 0;
      @(negedge clk_in);
      start = 0;
      dur = 1;
      while (!done && dur < 90000) begin
         @(negedge clk_in);
         dur++;
         if (dur == stall) begin
            `CHK("held", 1'b1, busy)
            rdy = 1;
         end
      end
      `CHK("done", 1'b1, done)
      repeat (8) @(negedge clk_in);
      `CHK("bytes", n, got[7:0])
      if (n != 8'h0) `CHK("far_rx", txd, frx)
      `CHK("overrun", 1'b0, ovr)
      $display("test done: code %0d cpha %0d inv %0d bytes %0d", c, e, i, n);
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard, a little beyond the longest expected run
   initial begin
      repeat (90000) @(posedge clk_in);
      fails++;
      test_done;
   end
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      dur = $urandom(97436);
      reboot(1'b1, 1'b0);
      `CHK("clk_idle", 1'b1, sck_o)
      for (int i = 0; i < 8; i++) xfer(i[2:0], i[0], i[1], {7'h0, i[2]} + 8'h1, 0);
      xfer(3'h0, 1'b1, 1'b0, 8'h0, 0);
      xfer(3'h0, 1'b0, 1'b1, 8'h4, 0);
      `CHK("pair_gap", 1'b1, dur >= 4000 && dur < 4300)
      xfer(3'h0, 1'b1, 1'b0, 8'd22, 42000);
      reboot(1'b1, 1'b1);
      xfer(3'h1, 1'b1, 1'b1, 8'h2, 0);
      `CHK("compat_oe", 1'b1, miso_oe)
      se = 1;
      reboot(1'b0, 1'b0);
      repeat (3) @(negedge clk_in);
      `CHK("float", 1'b0, miso_oe)
      ss = 0;
      inv = 0;
      ep = 1;
      repeat (3) @(negedge clk_in);
      `CHK("drive", 1'b1, miso_oe & ~sck_oe)
      $display("test done: slave select");
      // slave role: bench clocks 18 bytes with the drain held off, so the last one is lost
      ftx = 8'($urandom);
      txd = 8'($urandom);
      got = 0;
      rdy = 0;
      start = 1;
      cnt = 8'd18;
      @(negedge clk_in);
      start = 0;
      repeat (4) @(negedge clk_in);
      for (int b = 0; b < 18; b++) begin
         // bursts of at most 16 bytes, starts 8000 cycles apart, 20 Mbps peak
         if (b == 16) repeat (8000 - 16 * 80) @(negedge clk_in);
         for (int k = 7; k >= 0; k--) begin
            ssck = 0;
            sdo = ftx[k];
            repeat (5) @(negedge clk_in);
            ssck = 1;
            sq = {sq[6:0], miso_o};
            repeat (5) @(negedge clk_in);
         end
      end
      `CHK("slave_busy", 1'b0, busy)
      `CHK("slave_tx", txd, sq)
      `CHK("overrun_set", 1'b1, ovr)
      clr = 1;
      @(negedge clk_in);
      clr = 0;
      `CHK("overrun_clr", 1'b0, ovr)
      rdy = 1;
      repeat (30) @(negedge clk_in);
      `CHK("slave_bytes", 8'd17, got[7:0])
      $display("test done: slave overrun");
      test_done;
   end
endmodule
`default_nettype wire
